// File: rtl/skpl_core.sv
// Execution unit for skip, OR, load and store instructions
`timescale 1ns/1ps
`default_nettype none
module skpl_core
    import skpl_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RST,
    input  wire logic                CE,
    input  wire logic                INSTR_VALID,
    input  wire logic [INSTR_W-1:0]  INSTR,
    output logic      [DATA_W-1:0]   ACC,
    output logic                     ZERO_FLAG,
    output logic                     SKIPPING,
    output logic                     MEM_WE,
    output logic      [ADDR_W-1:0]   MEM_ADDR,
    output logic      [DATA_W-1:0]   MEM_WDATA,
    output logic      [DATA_W-1:0]   DBG_RDATA
);
    skpl_dec_if dif ();

    // Data memory, one bank of byte locations
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Accumulator and zero flag group
    logic [DATA_W-1:0] acc_r,   acc_nxt;
    logic              zf_r,    zf_nxt;
    // Skip state group
    skpl_state_t       st_r,    st_nxt;
    // Write port group
    logic              we_r,    we_nxt;
    logic [ADDR_W-1:0] wa_r,    wa_nxt;
    logic [DATA_W-1:0] wd_r,    wd_nxt;
    // Read-back group
    logic [DATA_W-1:0] rd_r,    rd_nxt;
    // Execute stage
    logic              take;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] res;
    logic              to_reg;
    logic              to_acc;

    // Zero test shared by skip and flag logic
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == ZERO_BYTE;
    endfunction

    // Register forms that honour the destination bit
    function automatic logic has_dest(input skpl_op_t op);
        return op == SKPL_DECSKIP || op == SKPL_INCSKIP || op == SKPL_ORREG;
    endfunction

    // Forms that may discard the next instruction
    function automatic logic is_skip_op(input skpl_op_t op);
        return op == SKPL_DECSKIP || op == SKPL_INCSKIP;
    endfunction

    // Forms whose result drives the zero flag
    function automatic logic sets_zero(input skpl_op_t op);
        return op == SKPL_ORREG || op == SKPL_ORLIT;
    endfunction

    // Field decode of the incoming word
    skpl_decoder u_dec (
        .instr (INSTR),
        .d     (dif.dec)
    );

    // Accepted this edge: valid and not being discarded by a pending skip
    assign take = INSTR_VALID && (st_r == SKPL_RUN);

    // Operand fetch, always the content before any write at this edge
    assign opnd = mem[dif.addr];

    // Result of the decoded operation
    always_comb begin
        case (dif.op)
            SKPL_DECSKIP: begin
                res = opnd - ONE_BYTE;
            end
            SKPL_INCSKIP: begin
                res = opnd + ONE_BYTE;
            end
            SKPL_ORREG: begin
                res = acc_r | opnd;
            end
            SKPL_ORLIT: begin
                res = acc_r | dif.lit;
            end
            SKPL_LDLIT: begin
                res = dif.lit;
            end
            SKPL_STORE: begin
                res = acc_r;
            end
            default: begin
                res = ZERO_BYTE;
            end
        endcase
    end

    // Destination routing for the accepted instruction
    always_comb begin
        to_reg = 1'b0;
        to_acc = 1'b0;
        if (take) begin
            if (has_dest(dif.op)) begin
                to_reg = dif.dest_reg;
                to_acc = !dif.dest_reg;
            end else if (dif.op == SKPL_STORE) begin
                to_reg = 1'b1;
            end else if (dif.op == SKPL_ORLIT || dif.op == SKPL_LDLIT) begin
                to_acc = 1'b1;
            end
        end
    end

    // Accumulator and zero flag next values; other forms leave the flag alone
    always_comb begin
        acc_nxt = acc_r;
        zf_nxt  = zf_r;
        if (to_acc) begin
            acc_nxt = res;
        end
        if (take && sets_zero(dif.op)) begin
            zf_nxt = is_zero(res);
        end
    end

    // Accumulator and zero flag registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            acc_r <= ACC_RESET;
            zf_r  <= 1'b0;
        end else if (CE) begin
            acc_r <= acc_nxt;
            zf_r  <= zf_nxt;
        end
    end

    // Skip state: a zero skip result discards the next valid word
    always_comb begin
        st_nxt = st_r;
        if (INSTR_VALID) begin
            case (st_r)
                SKPL_SKIP: begin
                    st_nxt = SKPL_RUN; // Discarded instruction acts as no-op
                end
                SKPL_RUN: begin
                    if (is_skip_op(dif.op) && is_zero(res)) begin
                        st_nxt = SKPL_SKIP;
                    end else begin
                        st_nxt = SKPL_RUN;
                    end
                end
                default: begin
                    st_nxt = SKPL_RUN;
                end
            endcase
        end
    end

    // Skip state register
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r <= SKPL_RUN;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // Write port next values; strobe lasts one enabled cycle
    always_comb begin
        we_nxt = 1'b0;
        wa_nxt = wa_r;
        wd_nxt = wd_r;
        if (to_reg) begin
            we_nxt = 1'b1;
            wa_nxt = dif.addr;
            wd_nxt = res;
        end
    end

    // Write port registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            we_r <= 1'b0;
            wa_r <= '0;
            wd_r <= ZERO_BYTE;
        end else if (CE) begin
            we_r <= we_nxt;
            wa_r <= wa_nxt;
            wd_r <= wd_nxt;
        end
    end

    // Read-back of the addressed location, pre-write
    always_comb begin
        rd_nxt = opnd;
    end

    // Read-back register
    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_r <= ZERO_BYTE;
        end else if (CE) begin
            rd_r <= rd_nxt;
        end
    end

    // Data memory write, same cycle as the executing instruction
    always_ff @(posedge CLK) begin
        if (CE && we_nxt) begin
            mem[wa_nxt] <= wd_nxt;
        end
    end

    // Outputs
    assign ACC       = acc_r;
    assign ZERO_FLAG = zf_r;
    assign SKIPPING  = (st_r == SKPL_SKIP);
    assign MEM_WE    = we_r;
    assign MEM_ADDR  = wa_r;
    assign MEM_WDATA = wd_r;
    assign DBG_RDATA = rd_r;
endmodule
`default_nettype wire

// File: rtl/skpl_pkg.sv
// Constants and types for the skip and logic instruction subset
package skpl_pkg;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 7;
    localparam int          MEM_DEPTH   = 128;
    localparam int          INSTR_W     = 14;
    localparam int          DEST_BIT    = 7;
    localparam int          LIT_MSB     = 7;
    // Opcode field bounds within the instruction word
    localparam int          OPC_MSB     = 13;
    localparam int          REG_OPC_LSB = 8;
    localparam int          STO_OPC_LSB = 7;
    localparam int          LDL_OPC_LSB = 10;
    // Opcode fields: bits 13:8 for register forms and OR literal, 13:7 for store, 13:10 for load literal
    localparam logic [5:0]  OPC_DECSKIP = 6'h0b;
    localparam logic [5:0]  OPC_INCSKIP = 6'h0f;
    localparam logic [5:0]  OPC_ORREG   = 6'h04;
    localparam logic [6:0]  OPC_STORE   = 7'h01;
    localparam logic [5:0]  OPC_ORLIT   = 6'h38;
    localparam logic [3:0]  OPC_LDLIT   = 4'hc;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    localparam logic [7:0]  ONE_BYTE    = 8'h01;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    typedef enum logic [2:0] {
        SKPL_NOP, SKPL_DECSKIP, SKPL_INCSKIP, SKPL_ORREG, SKPL_ORLIT, SKPL_LDLIT, SKPL_STORE
    } skpl_op_t;
    typedef enum { SKPL_RUN, SKPL_SKIP } skpl_state_t;
endpackage

// File: rtl/skpl_dec_if.sv
// Decoded instruction fields passed from decoder to core
`timescale 1ns/1ps
`default_nettype none
interface skpl_dec_if;
    import skpl_pkg::*;
    skpl_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic              dest_reg;
    logic [DATA_W-1:0] lit;
    modport dec  (output op, output addr, output dest_reg, output lit);
    modport core (input op, input addr, input dest_reg, input lit);
endinterface
`default_nettype wire

// File: rtl/skpl_decoder.sv
// Instruction word decoder for the subset
`timescale 1ns/1ps
`default_nettype none
module skpl_decoder
    import skpl_pkg::*;
(
    input wire logic [INSTR_W-1:0] instr,
    skpl_dec_if.dec                d
);
    // Field extraction and opcode match
    always_comb begin
        d.addr     = instr[ADDR_W-1:0];
        d.dest_reg = instr[DEST_BIT];
        d.lit      = instr[LIT_MSB:0];
        if (instr[OPC_MSB:REG_OPC_LSB] == OPC_DECSKIP) begin
            d.op = SKPL_DECSKIP;
        end else if (instr[OPC_MSB:REG_OPC_LSB] == OPC_INCSKIP) begin
            d.op = SKPL_INCSKIP;
        end else if (instr[OPC_MSB:REG_OPC_LSB] == OPC_ORREG) begin
            d.op = SKPL_ORREG;
        end else if (instr[OPC_MSB:STO_OPC_LSB] == OPC_STORE) begin
            d.op = SKPL_STORE;
        end else if (instr[OPC_MSB:REG_OPC_LSB] == OPC_ORLIT) begin
            d.op = SKPL_ORLIT;
        end else if (instr[OPC_MSB:LDL_OPC_LSB] == OPC_LDLIT) begin
            d.op = SKPL_LDLIT; // Bits 9:8 ignored; zeros accepted
        end else begin
            d.op = SKPL_NOP;
        end
    end
endmodule
`default_nettype wire

// File: verification/skpl_chk.sv
// Assertion checker for the skip and logic core
`timescale 1ns/1ps
`default_nettype none
module skpl_chk
    import skpl_pkg::*;
(
    input wire logic                CLK,
    input wire logic                RST,
    input wire logic                CE,
    input wire logic                INSTR_VALID,
    input wire logic [INSTR_W-1:0]  INSTR,
    input wire logic [DATA_W-1:0]   ACC,
    input wire logic                ZERO_FLAG,
    input wire logic                SKIPPING,
    input wire logic                MEM_WE,
    input wire logic [ADDR_W-1:0]   MEM_ADDR,
    input wire logic [DATA_W-1:0]   MEM_WDATA,
    input wire logic [DATA_W-1:0]   DBG_RDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Opcode and destination fields
    wire logic [5:0] opc = INSTR[13:8];
    wire logic       d   = INSTR[DEST_BIT];
    // Accepted instruction, or one dropped by a pending skip
    sequence s_run; CE && INSTR_VALID && !SKIPPING; endsequence
    sequence s_drop; CE && INSTR_VALID && SKIPPING; endsequence
    ld_lit_a: assert property (s_run ##0 (opc[5:2] == OPC_LDLIT) |=>
        ACC == $past(INSTR[7:0]) && $stable(ZERO_FLAG)) else $error("load literal wrong");
    or_lit_a: assert property (s_run ##0 (opc == OPC_ORLIT) |=>
        ACC == ($past(ACC) | $past(INSTR[7:0])) && ZERO_FLAG == (ACC == ZERO_BYTE)) else $error("or literal wrong");
    store_a: assert property (s_run ##0 ({opc, d} == OPC_STORE) |=> MEM_WE &&
        MEM_ADDR == $past(INSTR[6:0]) && MEM_WDATA == $past(ACC) && $stable(ZERO_FLAG)) else $error("store wrong");
    dec_skip_a: assert property (s_run ##0 (opc == OPC_DECSKIP && d) |=> MEM_WE &&
        MEM_WDATA == DBG_RDATA - ONE_BYTE && SKIPPING == (MEM_WDATA == ZERO_BYTE)) else $error("dec skip wrong");
    inc_skip_a: assert property (s_run ##0 (opc == OPC_INCSKIP && !d) |=> !MEM_WE &&
        ACC == DBG_RDATA + ONE_BYTE && SKIPPING == (ACC == ZERO_BYTE) && $stable(ZERO_FLAG)) else $error("inc skip wrong");
    or_reg_a: assert property (s_run ##0 (opc == OPC_ORREG && !d) |=>
        ACC == ($past(ACC) | DBG_RDATA) && ZERO_FLAG == (ACC == ZERO_BYTE)) else $error("or reg wrong");
    or_reg_dst_a: assert property (s_run ##0 (opc == OPC_ORREG && d) |=> MEM_WE &&
        MEM_WDATA == ($past(ACC) | DBG_RDATA) && $stable(ACC)) else $error("or reg dest wrong");
    skip_drop_a: assert property (s_drop |=> !SKIPPING && !MEM_WE && $stable(ACC))
        else $error("skip drop wrong");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Random self-checking bench for the skip and logic core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import skpl_pkg::*;
    logic               CLK = 0, RST = 1, CE = 1, INSTR_VALID = 0;
    logic [INSTR_W-1:0] INSTR = '0;
    logic [DATA_W-1:0]  ACC, MEM_WDATA, DBG_RDATA, acc = '0, wd = '0, rd = '0, r, kk, mem [MEM_DEPTH];
    logic [ADDR_W-1:0]  MEM_ADDR, wa = '0;
    logic               ZERO_FLAG, SKIPPING, MEM_WE, z = 1'b0, sk = 1'b0, we = 1'b0, rk = 1'b0;
    logic [34:0]        e, q [$];
    integer             seed = 32'he404, fails = 0, n_tests = 0, i, o;
    // Clock of 100 ns
    always #50 CLK = ~CLK;
    skpl_core skpl_core_inst (.CLK, .RST, .CE, .INSTR_VALID, .INSTR, .ACC, .ZERO_FLAG, .SKIPPING,
        .MEM_WE, .MEM_ADDR, .MEM_WDATA, .DBG_RDATA);
    // Compare one value
    task automatic check(input string nm, input logic [14:0] s, input logic [14:0] x);
        n_tests++;
        if (s !== x) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Drive one cycle and note the expected state
    task automatic issue(input int op, input logic d, input logic [6:0] a, input logic [7:0] k, input logic c, v);
        @(negedge CLK);
        CE = c;
        INSTR_VALID = v;
        case (op)
            0: INSTR = {OPC_DECSKIP, d, a};
            1: INSTR = {OPC_INCSKIP, d, a};
            2: INSTR = {OPC_ORREG, d, a};
            3: INSTR = {OPC_ORLIT, k};
            4: INSTR = {OPC_LDLIT, 2'b00, k};
            6: INSTR = {6'h00, 1'b0, a}; // Outside the subset
            default: INSTR = {OPC_STORE, a};
        endcase
        if (c) rd = mem[INSTR[ADDR_W-1:0]];
        if (c) we = 1'b0;
        if (c && v && sk) sk = 1'b0;
        else if (c && v && op < 6) begin
            r = op == 0 ? mem[a] - 8'h01 : op == 1 ? mem[a] + 8'h01 : op == 2 ? acc | mem[a] :
                op == 3 ? acc | k : op == 4 ? k : acc;
            if (op < 2) sk = r == 8'h00;
            if (op == 2 || op == 3) z = r == 8'h00;
            if (op > 2 && op < 5 || op < 3 && !d) acc = r;
            else begin
                mem[a] = r;
                we = 1;
                wa = a;
                wd = r;
            end
        end
        q.push_back({rk, rd, acc, z, sk, we, wa, wd});
    endtask
    // Take the oldest note once the edge has landed
    always @(posedge CLK) begin
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            check("acc", ACC, e[25:18]);
            check("flags", {ZERO_FLAG, SKIPPING, MEM_WE}, e[17:15]);
            if (e[15]) check("write", {MEM_ADDR, MEM_WDATA}, e[14:0]);
            if (e[34]) check("rdata", DBG_RDATA, e[33:26]);
        end
    end
    initial begin
        repeat (5) @(negedge CLK);
        RST = 0;
        for (i = 0; i < MEM_DEPTH; i++) begin
            issue(4, 1'b0, 7'h00, i[7:0], 1'b1, 1'b1);
            issue(5, 1'b0, i[6:0], 8'h00, 1'b1, 1'b1);
        end
        rk = 1'b1;
        repeat (3000) begin
            o = $random(seed);
            kk = $random(seed);
            if (kk[7:6] == 2'b11) kk = 8'hff;
            else if (kk[7]) kk = {7'h00, kk[0]};
            issue(o[2:0] % 7, o[3], o[17] ? o[20:14] : {3'h0, o[7:4]}, kk, o[11:8] != 0, o[13:12] != 0);
        end
        repeat (2) @(negedge CLK);
        close_out();
    end
    // Watchdog
    initial begin
        #1000000;
        fails++;
        close_out();
    end
endmodule
bind skpl_core skpl_chk skpl_chk_inst (.CLK, .RST, .CE, .INSTR_VALID, .INSTR, .ACC, .ZERO_FLAG, .SKIPPING,
    .MEM_WE, .MEM_ADDR, .MEM_WDATA, .DBG_RDATA);
`default_nettype wire
